// >>> hw/tpsc_panel.sv
// Purpose: front-panel control of the tape transport
// Assumes: sensor levels asynchronous to clk_i, buttons active high
// Notes: servo and motion sequencer report completion on seq_done
`timescale 1ns/100ps
`default_nettype none
module tpsc_panel #(
  parameter int unsigned DEBOUNCE_CYC = tpsc_pkg::DEBOUNCE_CYC,
  parameter int unsigned SETTLE_CYC = tpsc_pkg::SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire tpsc_pkg::tpsc_btn_t btn_i,
  input wire tpsc_pkg::tpsc_sense_t sense_i,
  output tpsc_pkg::tpsc_lamp_t lamp_o,
  output logic online_o,
  output logic ready_o,
  output logic selected_o,
  output logic servo_en_o,
  output logic load_seq_o,
  output logic rewind_seq_o,
  output logic unload_seq_o
);
  localparam int unsigned SW = $clog2(SETTLE_CYC + 1);
  localparam logic [SW-1:0] SLAST = SW'(SETTLE_CYC - 1);

  // a net, so that each debouncer drives its own bit of the struct
  wire tpsc_pkg::tpsc_btn_t press;
  tpsc_pkg::tpsc_sense_t s_meta;
  tpsc_pkg::tpsc_sense_t s;
  tpsc_pkg::tpsc_seq_t state;
  tpsc_pkg::tpsc_seq_t next_state;
  logic online;
  logic servo_en;
  logic [SW-1:0] settle_cnt;

  // one synchroniser and debouncer per pushbutton
  genvar gi;
  generate
    for (gi = 0; gi < $bits(tpsc_pkg::tpsc_btn_t); gi++) begin : g_btn
      tpsc_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .raw_i(btn_i[gi]),
        .press_o(press[gi])
      );
    end
  endgenerate

  wire idle = state == tpsc_pkg::TPSC_IDLE;
  wire local_ok = !online && idle;
  wire load_go = press.load && local_ok;
  wire rew_ok = press.rewind && local_ok && s.tensioned;
  wire rew_go = rew_ok && !s.at_bot;
  wire unload_go = rew_ok && s.at_bot;
  wire settled = settle_cnt == SLAST;
  wire at_or_past = s.at_bot || s.past_bot;

  // sequence control; a remote rewind also runs the rewind state
  always_comb begin
    next_state = state;
    unique case (state)
      tpsc_pkg::TPSC_IDLE: begin
        if (load_go) begin
          next_state = tpsc_pkg::TPSC_TENSION;
        end else if (rew_go) begin
          next_state = tpsc_pkg::TPSC_REWIND;
        end else if (unload_go) begin
          next_state = tpsc_pkg::TPSC_UNLOAD;
        end else if (s.remote_rew && online && s.remote_sel) begin
          next_state = tpsc_pkg::TPSC_REWIND;
        end
      end
      tpsc_pkg::TPSC_TENSION: begin
        if (s.tensioned && settled) begin
          next_state = tpsc_pkg::TPSC_LOAD;
        end
      end
      tpsc_pkg::TPSC_LOAD, tpsc_pkg::TPSC_REWIND,
      tpsc_pkg::TPSC_UNLOAD: begin
        if (s.seq_done) begin
          next_state = tpsc_pkg::TPSC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_meta <= '0;
      s <= '0;
    end else begin
      s_meta <= sense_i;
      s <= s_meta;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state <= tpsc_pkg::TPSC_IDLE;
      online <= 1'b0;
      servo_en <= 1'b0;
      settle_cnt <= '0;
    end else begin
      state <= next_state;
      if (press.online) begin
        online <= !online;
      end
      if (load_go) begin
        servo_en <= 1'b1;
      end else if (state == tpsc_pkg::TPSC_UNLOAD && s.seq_done) begin
        servo_en <= 1'b0;
      end
      settle_cnt <= (state == tpsc_pkg::TPSC_TENSION && s.tensioned &&
        !settled) ? settle_cnt + 1'b1 : '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      lamp_o <= '0;
      online_o <= 1'b0;
      ready_o <= 1'b0;
      selected_o <= 1'b0;
      servo_en_o <= 1'b0;
      load_seq_o <= 1'b0;
      rewind_seq_o <= 1'b0;
      unload_seq_o <= 1'b0;
    end else begin
      lamp_o.write <= s.write_stat;
      lamp_o.read <= s.read_stat;
      lamp_o.sel <= online && s.remote_sel;
      lamp_o.wr_en <= s.ring;
      lamp_o.online <= online;
      lamp_o.load <= servo_en && s.tensioned;
      lamp_o.rewind <= next_state == tpsc_pkg::TPSC_REWIND;
      online_o <= online;
      selected_o <= online && s.remote_sel;
      ready_o <= online && servo_en && s.tensioned && at_or_past &&
        next_state == tpsc_pkg::TPSC_IDLE;
      servo_en_o <= servo_en || load_go;
      load_seq_o <= next_state == tpsc_pkg::TPSC_LOAD;
      rewind_seq_o <= next_state == tpsc_pkg::TPSC_REWIND;
      unload_seq_o <= next_state == tpsc_pkg::TPSC_UNLOAD;
    end
  end
endmodule // tpsc_panel
`default_nettype wire

// >>> inc/tpsc_pkg.sv
// Purpose: constants and carrier types for the tape panel sequence control
// Assumes: 50 MHz clk_i, synchronous active-low reset
// Notes: sensor levels come from the transport and are synchronised
package tpsc_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned SETTLE_US = 100;
  localparam int unsigned SETTLE_CYC = CLK_HZ / 1_000_000 * SETTLE_US;

  typedef struct packed {
    logic online;
    logic load;
    logic rewind;
  } tpsc_btn_t;

  typedef struct packed {
    logic write_stat;
    logic read_stat;
    logic remote_sel;
    logic ring;
    logic tensioned;
    logic at_bot;
    logic past_bot;
    logic remote_rew;
    logic seq_done;
  } tpsc_sense_t;

  typedef struct packed {
    logic write;
    logic read;
    logic sel;
    logic wr_en;
    logic online;
    logic load;
    logic rewind;
  } tpsc_lamp_t;

  typedef enum logic [2:0] {
    TPSC_IDLE, TPSC_TENSION, TPSC_LOAD, TPSC_REWIND, TPSC_UNLOAD
  } tpsc_seq_t;
endpackage

// >>> hw/tpsc_debounce.sv
// Purpose: two-flop synchroniser, debounce and leading-edge pulse
// Assumes: raw pushbutton level, active high when pressed
// Notes: pulse lasts one clk_i cycle per accepted press
`timescale 1ns/100ps
`default_nettype none
module tpsc_debounce #(
  parameter int unsigned STABLE_CYC = tpsc_pkg::DEBOUNCE_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic raw_i,
  output logic press_o
);
  localparam int unsigned CW = $clog2(STABLE_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE_CYC - 1);
  logic meta;
  logic sync;
  logic stable;
  logic [CW-1:0] cnt;
  wire differ = sync != stable;
  wire settle = differ && (cnt == LAST);
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      stable <= 1'b0;
      cnt <= '0;
      press_o <= 1'b0;
    end else begin
      meta <= raw_i;
      sync <= meta;
      cnt <= (differ && !settle) ? cnt + 1'b1 : '0;
      if (settle) begin
        stable <= sync;
      end
      press_o <= settle && sync;
    end
  end
endmodule // tpsc_debounce
`default_nettype wire

// >>> tb/tpsc_checker.sv
// Purpose: port assertions for the tape panel
// Assumes: lamps follow sensors three edges late
// Notes: bound to tpsc_panel from the testbench
`timescale 1ns/100ps
`default_nettype none
module tpsc_checker (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire tpsc_pkg::tpsc_sense_t sense_i,
  input wire tpsc_pkg::tpsc_lamp_t lamp_o,
  input wire logic online_o,
  input wire logic ready_o,
  input wire logic selected_o,
  input wire logic servo_en_o,
  input wire logic rewind_seq_o,
  input wire logic unload_seq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_write_lamp: assert property (
    $stable(sense_i.write_stat)[*4] |-> lamp_o.write == sense_i.write_stat)
    else $error("write lamp wrong");
  a_read_lamp: assert property (
    $stable(sense_i.read_stat)[*4] |-> lamp_o.read == sense_i.read_stat)
    else $error("read lamp wrong");
  a_ring_lamp: assert property (
    $stable(sense_i.ring)[*4] |-> lamp_o.wr_en == sense_i.ring)
    else $error("write enable lamp wrong");
  a_sel_off: assert property (
    !online_o[*3] |-> !lamp_o.sel && !selected_o)
    else $error("select shown off line");
  a_online_lamp: assert property (
    $stable(online_o)[*3] |-> lamp_o.online == online_o)
    else $error("on-line lamp wrong");
  a_ready_gate: assert property (
    !online_o[*2] |-> !ready_o)
    else $error("ready while off line");
  a_load_lamp: assert property (
    !servo_en_o[*2] |-> !lamp_o.load)
    else $error("load lamp without servo");
  a_unload_gate: assert property (
    $rose(unload_seq_o) |-> !online_o)
    else $error("unload started on line");
  a_rew_lamp: assert property (
    rewind_seq_o[*2] |-> lamp_o.rewind)
    else $error("rewind lamp dark");
  a_toggle_once: assert property (
    $changed(online_o) |=> $stable(online_o)[*4])
    else $error("on-line toggled twice");
endmodule // tpsc_checker
`default_nettype wire

// >>> tb/tpsc_reel.sv
// Purpose: reel servo and motion sequencer stand-in
// Assumes: tension follows servo enable one edge late
// Notes: DLY sets how slowly a sequence completes
`timescale 1ns/100ps
`default_nettype none
module tpsc_reel #(
  parameter int DLY = 30
) (
  input wire logic clk_i,
  input wire logic servo_en_i,
  input wire logic busy_i,
  output logic tensioned_o,
  output logic seq_done_o
);
  int cnt = 0;
  initial tensioned_o = 1'b0;
  initial seq_done_o = 1'b0;
  always @(posedge clk_i) begin
    tensioned_o <= servo_en_i;
    cnt <= busy_i ? cnt + 1 : 0;
    seq_done_o <= busy_i && cnt >= DLY;
  end
endmodule // tpsc_reel
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for tpsc_panel
// Assumes: short debounce and settle counts
// Notes: whole output vector compared against a bench model
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  tpsc_pkg::tpsc_btn_t btn_i = '0;
  tpsc_pkg::tpsc_sense_t sense_i;
  tpsc_pkg::tpsc_lamp_t lamp_o;
  logic online_o, ready_o, selected_o, servo_en_o;
  logic load_seq_o, rewind_seq_o, unload_seq_o, ten, done;
  logic [2:0] sv = '0;
  logic sel = 0, bot = 0, past = 0, rrew = 0;
  logic on = 0, srv = 0, ld = 0, rw = 0, ul = 0;
  logic [13:0] q[$];
  int fail_count = 0;
  int checks = 0;
  event look;
  wire [13:0] obs = {lamp_o, online_o, ready_o, selected_o, servo_en_o,
    load_seq_o, rewind_seq_o, unload_seq_o};
  wire busy = load_seq_o | rewind_seq_o | unload_seq_o;
  always #10 clk_i = ~clk_i;
  assign sense_i = {sv[2:1], sel, sv[0], ten, bot, past, rrew, done};
  tpsc_panel #(.DEBOUNCE_CYC(4), .SETTLE_CYC(3)) tpsc_panel_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .btn_i(btn_i), .sense_i(sense_i),
    .lamp_o(lamp_o), .online_o(online_o), .ready_o(ready_o),
    .selected_o(selected_o), .servo_en_o(servo_en_o),
    .load_seq_o(load_seq_o), .rewind_seq_o(rewind_seq_o),
    .unload_seq_o(unload_seq_o));
  tpsc_reel tpsc_reel_i (.clk_i(clk_i), .servo_en_i(servo_en_o),
    .busy_i(busy), .tensioned_o(ten), .seq_done_o(done));
  task automatic same(string what, logic [13:0] seen, logic [13:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // oldest note against the settled outputs
  always @(look) same("outputs", obs, q.pop_front());
  task automatic note(string s);
    @(negedge clk_i);
    q.push_back({sv[2:1], on & sel, sv[0], on, srv, rw, on,
      on & srv & (bot | past) & !(ld | rw | ul), on & sel, srv, ld, rw, ul});
    ->look;
    $display("test %s done", s);
    @(posedge clk_i);
  endtask
  task automatic press(int b);
    btn_i[b] <= 1'b1;
    repeat (8) @(posedge clk_i);
    btn_i[b] <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 200 && busy !== 1'b0; n++) @(posedge clk_i);
    if (n == 200) begin
      fail_count++;
      report_and_stop();
    end
    repeat (6) @(posedge clk_i);
  endtask
  task automatic report_and_stop();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(37));
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    sv <= 3'($urandom);
    repeat (5) @(posedge clk_i);
    note("reset");
    press(0);
    note("rewind slack");
    press(1);
    srv = 1;
    ld = 1;
    note("load");
    wait_idle();
    ld = 0;
    bot <= 1'b1;
    sel <= 1'b1;
    press(2);
    on = 1;
    note("online");
    press(1);
    press(0);
    note("locked");
    rrew <= 1'b1;
    repeat (6) @(posedge clk_i);
    rrew <= 1'b0;
    rw = 1;
    note("remote rewind");
    wait_idle();
    rw = 0;
    sv <= 3'($urandom);
    press(2);
    on = 0;
    note("offline");
    bot <= 1'b0;
    past <= 1'b1;
    press(0);
    rw = 1;
    note("rewind");
    wait_idle();
    rw = 0;
    bot <= 1'b1;
    past <= 1'b0;
    press(0);
    ul = 1;
    note("unload");
    wait_idle();
    ul = 0;
    srv = 0;
    note("unloaded");
    report_and_stop();
  end
endmodule // testbench
bind tpsc_panel tpsc_checker tpsc_checker_i (.clk_i(clk_i),
  .nrst_i(nrst_i), .sense_i(sense_i), .lamp_o(lamp_o),
  .online_o(online_o), .ready_o(ready_o), .selected_o(selected_o),
  .servo_en_o(servo_en_o), .rewind_seq_o(rewind_seq_o),
  .unload_seq_o(unload_seq_o));
`default_nettype wire
